// ==== dcfm_pkg.sv ====
// constants, field layout and shared helper functions of the clocked fifo
// with mailboxes; assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package dcfm_pkg;

  // ****************************************************************
  // sizes and field layout
  // ****************************************************************
  localparam int DCFM_WIDTH = 36;
  localparam int DCFM_ADDR_W = 6;
  localparam int DCFM_PTR_W = 7;
  localparam int DCFM_BYTE_W = 9;
  localparam int DCFM_NBYTES = 4;
  localparam int DCFM_PAR_BIT = 8; // parity bit inside each 9-bit byte
  localparam logic [6:0] DCFM_DEPTH = 7'h40;
  localparam logic [1:0] DCFM_BUF_DEPTH = 2'h2;

  // ****************************************************************
  // reset values and preset almost-flag offsets
  // ****************************************************************
  localparam logic [6:0] DCFM_OFFSET_0 = 7'h10;
  localparam logic [6:0] DCFM_OFFSET_1 = 7'h0C;
  localparam logic [6:0] DCFM_OFFSET_2 = 7'h08;
  localparam logic [6:0] DCFM_OFFSET_3 = 7'h04;
  localparam logic [6:0] DCFM_OFFSET_RST = 7'h00;
  localparam logic [1:0] DCFM_INIT_RST = 2'h0;
  localparam int DCFM_RESET_EDGES = 4; // edges per clock the far side holds

  // pointer to gray code, used by both clock domains
  function automatic logic [6:0] dcfm_bin2gray(input logic [6:0] b);
    return b ^ (b >> 1);
  endfunction

  // gray code back to binary
  function automatic logic [6:0] dcfm_gray2bin(input logic [6:0] g);
    logic [6:0] b;
    b[6] = g[6];
    for (int i = 5; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // offset chosen by the two select inputs
  function automatic logic [6:0] dcfm_offset(input logic s1, input logic s0);
    logic [6:0] v;
    case ({s1, s0})
      2'h0: v = DCFM_OFFSET_0;
      2'h1: v = DCFM_OFFSET_1;
      2'h2: v = DCFM_OFFSET_2;
      default: v = DCFM_OFFSET_3;
    endcase
    return v;
  endfunction

  // high when any byte of the word fails the chosen parity sense
  function automatic logic dcfm_par_fail(input logic [35:0] w,
                                         input logic odd);
    logic f;
    f = 1'b0;
    for (int i = 0; i < DCFM_NBYTES; i++) begin
      f = f | ((^w[i*DCFM_BYTE_W +: DCFM_BYTE_W]) != odd);
    end
    return f;
  endfunction

  // word with each byte's top bit replaced by generated parity
  function automatic logic [35:0] dcfm_par_fill(input logic [35:0] w,
                                                input logic odd);
    logic [35:0] r;
    r = w;
    for (int i = 0; i < DCFM_NBYTES; i++) begin
      r[i*DCFM_BYTE_W+DCFM_PAR_BIT] =
        (^w[i*DCFM_BYTE_W +: DCFM_PAR_BIT]) ^ odd;
    end
    return r;
  endfunction

endpackage

`default_nettype wire

// ==== dcfm_mem.sv ====
// 64 x 36 two-clock storage array with registered read data.
// assumes write and read addresses never collide on a live word.
`timescale 1ns/1ps
`default_nettype none

module dcfm_mem
  import dcfm_pkg::*;
(
  // write side, port a clock
  input wire logic wclk_in,
  input wire logic wen_in,
  input wire logic [5:0] waddr_in,
  input wire logic [35:0] wdata_in,
  // read side, port b clock
  input wire logic rclk_in,
  input wire logic rresetn_in,
  input wire logic ren_in,
  input wire logic [5:0] raddr_in,
  output logic [35:0] rdata_out
);

  logic [35:0] mem_array [0:63];

  // ****************************************************************
  // write port
  // ****************************************************************
  // no reset on the array: contents are meaningless until written
  always_ff @(posedge wclk_in) begin
    if (wen_in) begin
      mem_array[waddr_in] <= wdata_in;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  // read data leaves from a register so the output path is clean
  always_ff @(posedge rclk_in or negedge rresetn_in) begin
    if (!rresetn_in) begin
      rdata_out <= '0;
    end else if (ren_in) begin
      rdata_out <= mem_array[raddr_in];
    end
  end

endmodule

`default_nettype wire

// ==== dcfm_top.sv ====
// clocked 64 x 36 fifo from port a to port b, with one mailbox each way,
// passive byte parity checking and optional parity generation.
// assumes enables and data are synchronous to their own port clock.
//
// Notes on behaviour
// - words written at port a leave port b in order, 64 deep, 36 wide
// - each port runs on its own clock, no relation between them assumed
// - transfers happen on a port clock edge while its enables are on; the port b output buffer pops on read ready alone
// - full and almost-full come from port a clock via two-stage sync
// - empty and almost-empty come from port b clock via two-stage sync
// - two 36-bit mailboxes, one per direction, bypass the fifo
// - each mailbox has a flag showing unread mail
// - byte parity checked on each port, errors flagged except during a mailbox read with parity generation on, transfers unaffected
// - parity bits of read data optionally regenerated, odd or even
// - four 9-bit bytes, parity in bits 8, 17, 26 and 35
// - offset selects caught at reset release, held stable by outside
// - reset: empty, almost-empty, full low; almost-full, mail flags high
// - empty clears on second read-clock edge; reads blocked while empty
// - almost flags assert at or below the selected offset
// - mailbox write sets flag, blocks writes until other port reads it
`timescale 1ns/1ps
`default_nettype none

module dcfm_top
  import dcfm_pkg::*;
(
  // clocks and reset
  input wire logic CLK_IN,
  input wire logic PORT_B_CLOCK_IN,
  input wire logic RESETN_IN,
  // configuration
  input wire logic OFFSET_SELECT_0_IN,
  input wire logic OFFSET_SELECT_1_IN,
  input wire logic ODD_PARITY_IN,
  // port a control
  input wire logic PORT_A_SELECT_N_IN,
  input wire logic PORT_A_ENABLE_IN,
  input wire logic PORT_A_WRITE_NOT_READ_IN,
  input wire logic PORT_A_MAILBOX_SELECT_IN,
  input wire logic PORT_A_PARITY_GEN_IN,
  // port a data pins
  input wire logic [35:0] PORT_A_DATA_IN,
  output logic [35:0] PORT_A_DATA_OUT,
  output logic PORT_A_DATA_OE_OUT,
  // port a status
  output logic FULL_FLAG_N_OUT,
  output logic ALMOST_FULL_FLAG_N_OUT,
  output logic MAILBOX_AB_FLAG_N_OUT,
  output logic PORT_A_PARITY_ERROR_N_OUT,
  // port b control
  input wire logic PORT_B_SELECT_N_IN,
  input wire logic PORT_B_ENABLE_IN,
  input wire logic PORT_B_WRITE_NOT_READ_IN,
  input wire logic PORT_B_MAILBOX_SELECT_IN,
  input wire logic PORT_B_PARITY_GEN_IN,
  // port b data pins and read handshake
  input wire logic [35:0] PORT_B_DATA_IN,
  output logic [35:0] PORT_B_DATA_OUT,
  output logic PORT_B_DATA_OE_OUT,
  output logic PORT_B_READ_VALID_OUT,
  input wire logic PORT_B_READ_READY_IN,
  // port b status
  output logic EMPTY_FLAG_N_OUT,
  output logic ALMOST_EMPTY_FLAG_N_OUT,
  output logic MAILBOX_BA_FLAG_N_OUT,
  output logic PORT_B_PARITY_ERROR_N_OUT
);

  // ****************************************************************
  // port a clock domain: fifo write side and mailbox a-to-b writer
  // ****************************************************************
  logic [6:0] wr_bin_reg, wr_gray_reg, rd_gray_a1_reg, rd_gray_a2_reg;
  logic [6:0] offset_a_reg;
  logic [1:0] init_a_reg;
  logic loaded_a_reg, ab_tog_reg, ba_ack_reg, ab_ack_a1_reg, ab_ack_a2_reg;
  logic ba_tog_a1_reg, ba_tog_a2_reg;
  logic [35:0] mail_ab_reg;
  wire logic a_act;
  wire logic a_fifo_wr_req, a_fifo_wr, a_mail_wr_req, a_mail_wr, a_mail_rd;
  wire logic [6:0] rd_bin_a, used_a, free_a;
  wire logic full_a, full_n_a, mailbox_ab_flag_n_n;
  // port b state read across the boundary, declared before first use
  logic [6:0] rd_bin_reg, rd_gray_reg, wr_gray_b1_reg, wr_gray_b2_reg;
  logic loaded_b_reg, ba_tog_reg, ab_ack_reg, ba_ack_b1_reg, ba_ack_b2_reg;
  logic [35:0] mail_ba_reg, mem_q;

  // request decode; only a qualified edge moves anything
  assign a_act = ~PORT_A_SELECT_N_IN & PORT_A_ENABLE_IN;
  assign a_fifo_wr_req = a_act & PORT_A_WRITE_NOT_READ_IN &
                         ~PORT_A_MAILBOX_SELECT_IN;
  assign a_fifo_wr = a_fifo_wr_req & full_n_a;
  assign a_mail_wr_req = a_act & PORT_A_WRITE_NOT_READ_IN &
                         PORT_A_MAILBOX_SELECT_IN;
  assign a_mail_wr = a_mail_wr_req & mailbox_ab_flag_n_n;
  assign a_mail_rd = a_act & ~PORT_A_WRITE_NOT_READ_IN &
                     PORT_A_MAILBOX_SELECT_IN;

  // occupancy seen from the write side through the synced read pointer
  assign rd_bin_a = dcfm_gray2bin(rd_gray_a2_reg);
  assign used_a = wr_bin_reg - rd_bin_a;
  assign full_a = (used_a == DCFM_DEPTH);
  assign free_a = DCFM_DEPTH - used_a;
  // full stays asserted until the second edge after reset release
  assign full_n_a = init_a_reg[1] & ~full_a;
  assign mailbox_ab_flag_n_n = (ab_tog_reg == ab_ack_a2_reg);

  // write pointer, kept in binary and gray
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wr_bin_reg <= '0;
      wr_gray_reg <= '0;
    end else if (a_fifo_wr) begin
      wr_bin_reg <= wr_bin_reg + 7'h01;
      wr_gray_reg <= dcfm_bin2gray(wr_bin_reg + 7'h01);
    end
  end

  // two-stage sync of read pointer and mailbox toggles into port a
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rd_gray_a1_reg <= '0;
      rd_gray_a2_reg <= '0;
      ab_ack_a1_reg <= 1'b0;
      ab_ack_a2_reg <= 1'b0;
      ba_tog_a1_reg <= 1'b0;
      ba_tog_a2_reg <= 1'b0;
    end else begin
      rd_gray_a1_reg <= rd_gray_reg;
      rd_gray_a2_reg <= rd_gray_a1_reg;
      ab_ack_a1_reg <= ab_ack_reg;
      ab_ack_a2_reg <= ab_ack_a1_reg;
      ba_tog_a1_reg <= ba_tog_reg;
      ba_tog_a2_reg <= ba_tog_a1_reg;
    end
  end

  // offset caught on the first edge after release; straps must be steady
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      init_a_reg <= DCFM_INIT_RST;
      loaded_a_reg <= 1'b0;
      offset_a_reg <= DCFM_OFFSET_RST;
    end else begin
      init_a_reg <= {init_a_reg[0], 1'b1};
      loaded_a_reg <= 1'b1;
      if (!loaded_a_reg) begin
        offset_a_reg <= dcfm_offset(OFFSET_SELECT_1_IN,
                                    OFFSET_SELECT_0_IN);
      end
    end
  end

  // mailbox a-to-b store, and the acknowledge of mailbox b-to-a
  // a toggle per event: set and clear can never meet in one register
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      mail_ab_reg <= '0;
      ab_tog_reg <= 1'b0;
      ba_ack_reg <= 1'b0;
    end else begin
      if (a_mail_wr) begin
        mail_ab_reg <= PORT_A_DATA_IN;
        ab_tog_reg <= ~ab_tog_reg;
      end
      if (a_mail_rd) begin
        ba_ack_reg <= ba_tog_a2_reg;
      end
    end
  end

  // port a outputs; the parity check and the mailbox parity generation use separate trees
  assign FULL_FLAG_N_OUT = full_n_a;
  assign ALMOST_FULL_FLAG_N_OUT = ~(free_a <= offset_a_reg);
  assign MAILBOX_AB_FLAG_N_OUT = mailbox_ab_flag_n_n;
  assign PORT_A_DATA_OUT = PORT_A_PARITY_GEN_IN ?
    dcfm_par_fill(mail_ba_reg, ODD_PARITY_IN) : mail_ba_reg;
  assign PORT_A_DATA_OE_OUT = ~PORT_A_SELECT_N_IN &
                              ~PORT_A_WRITE_NOT_READ_IN;
  assign PORT_A_PARITY_ERROR_N_OUT = (a_mail_rd & PORT_A_PARITY_GEN_IN) |
    ~dcfm_par_fail(PORT_A_DATA_IN, ODD_PARITY_IN);

  // ****************************************************************
  // port b clock domain: fifo read side and mailbox b-to-a writer
  // ****************************************************************
  logic [6:0] offset_b_reg;
  logic ab_tog_b1_reg, ab_tog_b2_reg, mem_vld_reg;
  logic [35:0] buf0_reg, buf1_reg, buf0_next, buf1_next;
  logic [1:0] buf_cnt_reg, buf_cnt_next;
  wire logic b_act, b_fifo_rd, b_mail_wr, b_mail_rd, buf_room, buf_pop;
  wire logic empty_n_b, mailbox_ba_flag_n_n;
  wire logic [6:0] wr_bin_b, used_b;
  wire logic [35:0] b_word;

  // occupancy seen from the read side through the synced write pointer
  assign wr_bin_b = dcfm_gray2bin(wr_gray_b2_reg);
  assign used_b = wr_bin_b - rd_bin_reg;
  assign empty_n_b = (used_b != 7'h00);
  assign mailbox_ba_flag_n_n = (ba_tog_reg == ba_ack_b2_reg);

  // request decode; a fifo read also needs room in the output buffer
  assign b_act = ~PORT_B_SELECT_N_IN & PORT_B_ENABLE_IN;
  assign buf_room = (buf_cnt_reg == 2'h0) |
                    ((buf_cnt_reg == 2'h1) & ~mem_vld_reg);
  assign b_fifo_rd = b_act & ~PORT_B_WRITE_NOT_READ_IN &
                     ~PORT_B_MAILBOX_SELECT_IN & empty_n_b & buf_room;
  assign b_mail_rd = b_act & ~PORT_B_WRITE_NOT_READ_IN &
                     PORT_B_MAILBOX_SELECT_IN;
  assign b_mail_wr = b_act & PORT_B_WRITE_NOT_READ_IN &
                     PORT_B_MAILBOX_SELECT_IN & mailbox_ba_flag_n_n;
  assign buf_pop = (buf_cnt_reg != 2'h0) & PORT_B_READ_READY_IN;

  // read pointer, kept in binary and gray
  always_ff @(posedge PORT_B_CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rd_bin_reg <= '0;
      rd_gray_reg <= '0;
    end else if (b_fifo_rd) begin
      rd_bin_reg <= rd_bin_reg + 7'h01;
      rd_gray_reg <= dcfm_bin2gray(rd_bin_reg + 7'h01);
    end
  end

  // two-stage sync of write pointer and mailbox toggles into port b
  always_ff @(posedge PORT_B_CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      wr_gray_b1_reg <= '0;
      wr_gray_b2_reg <= '0;
      ba_ack_b1_reg <= 1'b0;
      ba_ack_b2_reg <= 1'b0;
      ab_tog_b1_reg <= 1'b0;
      ab_tog_b2_reg <= 1'b0;
    end else begin
      wr_gray_b1_reg <= wr_gray_reg;
      wr_gray_b2_reg <= wr_gray_b1_reg;
      ba_ack_b1_reg <= ba_ack_reg;
      ba_ack_b2_reg <= ba_ack_b1_reg;
      ab_tog_b1_reg <= ab_tog_reg;
      ab_tog_b2_reg <= ab_tog_b1_reg;
    end
  end

  // offset, mailbox b-to-a store and acknowledge of mailbox a-to-b
  always_ff @(posedge PORT_B_CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      loaded_b_reg <= 1'b0;
      offset_b_reg <= DCFM_OFFSET_RST;
      mail_ba_reg <= '0;
      ba_tog_reg <= 1'b0;
      ab_ack_reg <= 1'b0;
      mem_vld_reg <= 1'b0;
    end else begin
      loaded_b_reg <= 1'b1;
      mem_vld_reg <= b_fifo_rd;
      if (!loaded_b_reg) begin
        offset_b_reg <= dcfm_offset(OFFSET_SELECT_1_IN,
                                    OFFSET_SELECT_0_IN);
      end
      if (b_mail_wr) begin
        mail_ba_reg <= PORT_B_DATA_IN;
        ba_tog_reg <= ~ba_tog_reg;
      end
      if (b_mail_rd) begin
        ab_ack_reg <= ab_tog_b2_reg;
      end
    end
  end

  // storage array
  dcfm_mem u_mem (
    .wclk_in(CLK_IN),
    .wen_in(a_fifo_wr),
    .waddr_in(wr_bin_reg[5:0]),
    .wdata_in(PORT_A_DATA_IN),
    .rclk_in(PORT_B_CLOCK_IN),
    .rresetn_in(RESETN_IN),
    .ren_in(b_fifo_rd),
    .raddr_in(rd_bin_reg[5:0]),
    .rdata_out(mem_q)
  );

  // two-entry output buffer; a stalled receiver stops further fifo reads
  always_comb begin
    buf0_next = buf0_reg;
    buf1_next = buf1_reg;
    buf_cnt_next = buf_cnt_reg;
    case ({mem_vld_reg, buf_pop})
      2'b11: begin
        buf0_next = (buf_cnt_reg == 2'h1) ? mem_q : buf1_reg;
        buf1_next = mem_q;
      end
      2'b01: begin
        buf0_next = buf1_reg;
        buf_cnt_next = buf_cnt_reg - 2'h1;
      end
      2'b10: begin
        if (buf_cnt_reg == 2'h0) begin
          buf0_next = mem_q;
        end else begin
          buf1_next = mem_q;
        end
        buf_cnt_next = buf_cnt_reg + 2'h1;
      end
      default: begin
        buf_cnt_next = buf_cnt_reg;
      end
    endcase
  end

  // buffer registers
  always_ff @(posedge PORT_B_CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      buf0_reg <= '0;
      buf1_reg <= '0;
      buf_cnt_reg <= 2'h0;
    end else begin
      buf0_reg <= buf0_next;
      buf1_reg <= buf1_next;
      buf_cnt_reg <= buf_cnt_next;
    end
  end

  // port b outputs: mailbox select picks mail over the fifo head
  assign b_word = PORT_B_MAILBOX_SELECT_IN ? mail_ab_reg : buf0_reg;
  assign PORT_B_DATA_OUT = PORT_B_PARITY_GEN_IN ?
    dcfm_par_fill(b_word, ODD_PARITY_IN) : b_word;
  assign PORT_B_DATA_OE_OUT = ~PORT_B_SELECT_N_IN &
                              ~PORT_B_WRITE_NOT_READ_IN;
  assign PORT_B_READ_VALID_OUT = (buf_cnt_reg != 2'h0);
  assign EMPTY_FLAG_N_OUT = empty_n_b;
  assign ALMOST_EMPTY_FLAG_N_OUT = ~(used_b <= offset_b_reg);
  assign MAILBOX_BA_FLAG_N_OUT = mailbox_ba_flag_n_n;
  assign PORT_B_PARITY_ERROR_N_OUT = (b_mail_rd & PORT_B_PARITY_GEN_IN) |
    ~dcfm_par_fail(PORT_B_DATA_IN, ODD_PARITY_IN);

  // ****************************************************************
  // checks
  // ****************************************************************
  full_block_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    a_fifo_wr_req && !full_n_a |=> wr_bin_reg == $past(wr_bin_reg))
    else $error("write moved pointer while full");
  empty_block_a: assert property (@(posedge PORT_B_CLOCK_IN)
    disable iff (!RESETN_IN)
    !empty_n_b |=> rd_bin_reg == $past(rd_bin_reg))
    else $error("read moved pointer while empty");
  mbox_block_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    a_mail_wr_req && !mailbox_ab_flag_n_n |=> mail_ab_reg == $past(mail_ab_reg))
    else $error("mailbox overwritten while flag low");
  mbox_set_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    a_mail_wr |=> !MAILBOX_AB_FLAG_N_OUT [*2])
    else $error("mailbox flag not set by write");
  full_almost_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    full_a |-> !FULL_FLAG_N_OUT && !ALMOST_FULL_FLAG_N_OUT)
    else $error("full without almost full");
  empty_almost_a: assert property (@(posedge PORT_B_CLOCK_IN)
    disable iff (!RESETN_IN)
    !EMPTY_FLAG_N_OUT |-> !ALMOST_EMPTY_FLAG_N_OUT)
    else $error("empty without almost empty");
  gray_step_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $onehot0(wr_gray_reg ^ $past(wr_gray_reg)))
    else $error("write gray pointer moved more than one bit");
  offset_load_a: assert property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    $rose(loaded_a_reg) |=> offset_a_reg == dcfm_offset(
      $past(OFFSET_SELECT_1_IN, 2), $past(OFFSET_SELECT_0_IN, 2)))
    else $error("offset not taken from selects at release");
  parity_force_a: assert property (@(posedge PORT_B_CLOCK_IN)
    disable iff (!RESETN_IN)
    b_mail_rd && PORT_B_PARITY_GEN_IN |-> PORT_B_PARITY_ERROR_N_OUT)
    else $error("parity error shown during generated mail read");
  buf_bound_a: assert property (@(posedge PORT_B_CLOCK_IN)
    disable iff (!RESETN_IN)
    buf_cnt_reg <= DCFM_BUF_DEPTH && !(mem_vld_reg && buf_cnt_reg == 2'h2))
    else $error("output buffer overrun");
  full_seen_c: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    full_a);
  mail_trip_c: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !mailbox_ab_flag_n_n ##[1:20] mailbox_ab_flag_n_n);
  buf_stall_c: cover property (@(posedge PORT_B_CLOCK_IN)
    disable iff (!RESETN_IN) buf_cnt_reg == 2'h2 && !PORT_B_READ_READY_IN);
  par_err_c: cover property (@(posedge CLK_IN) disable iff (!RESETN_IN)
    !PORT_A_PARITY_ERROR_N_OUT);

endmodule

`default_nettype wire

// ==== dcfm_reader.sv ====
// port b far side: a synchronous bus master that reads the fifo and
// uses the mailboxes; assumes the testbench steers it with level requests.
`timescale 1ns/1ps
`default_nettype none

module dcfm_reader (
  // steering from the testbench
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic stall_in,
  input wire logic mrd_in,
  input wire logic mwr_in,
  input wire logic [35:0] md_in,
  // port b pins
  output logic sel_n_out,
  output logic en_out,
  output logic wnr_out,
  output logic mb_out,
  output logic rdy_out,
  output logic [35:0] d_out
);
  // ****************************************************************
  // request driver
  // ****************************************************************
  // idle and deselected until the first request
  initial begin
    {sel_n_out, en_out, wnr_out, mb_out, rdy_out} = 5'h11;
    d_out = 36'h0;
  end

  // change just after the falling edge, hold a whole cycle
  always @(negedge clk_in) begin
    sel_n_out <= !(go_in | mrd_in | mwr_in);
    en_out <= go_in | mrd_in | mwr_in;
    wnr_out <= mwr_in;
    mb_out <= mrd_in | mwr_in;
    rdy_out <= !stall_in;
    // a released bus must not keep showing the last word
    d_out <= mwr_in ? md_in : ~d_out;
  end
endmodule

`default_nettype wire

// ==== dcfm_top_test.sv ====
// self-checking bench for the two-clock fifo with mailboxes.
// assumes dcfm_top and the port b reader model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module dcfm_top_test;
  logic clk = 0, port_b_clock = 0, rst_n = 0, fs0 = 0, fs1 = 0, odd = 0;
  logic a_sel_n = 1, a_en = 0, a_wnr = 0, a_mb = 0, a_pg = 0, b_pg = 0;
  logic go = 0, stall = 0, mrd = 0, mwr = 0;
  logic [35:0] a_d = 0, md = 0, b_d, a_q, b_q;
  logic b_sel_n, b_en, b_wnr, b_mb, b_rdy, a_oe, b_oe, b_vld;
  logic ff_n, af_n, mab_n, pea_n, ef_n, ae_n, mba_n, peb_n;
  logic [35:0] q[$];
  int n_mismatch = 0, checks = 0, seq = 0;

  // unrelated port clocks: 25 ns and 22 ns
  always #12.5 clk = ~clk;
  always #11 port_b_clock = ~port_b_clock;

  dcfm_top dut_u (.CLK_IN(clk), .PORT_B_CLOCK_IN(port_b_clock), .RESETN_IN(rst_n),
    .OFFSET_SELECT_0_IN(fs0), .OFFSET_SELECT_1_IN(fs1),
    .ODD_PARITY_IN(odd), .PORT_A_SELECT_N_IN(a_sel_n),
    .PORT_A_ENABLE_IN(a_en), .PORT_A_WRITE_NOT_READ_IN(a_wnr),
    .PORT_A_MAILBOX_SELECT_IN(a_mb), .PORT_A_PARITY_GEN_IN(a_pg),
    .PORT_A_DATA_IN(a_d), .PORT_A_DATA_OUT(a_q), .PORT_A_DATA_OE_OUT(a_oe),
    .FULL_FLAG_N_OUT(ff_n), .ALMOST_FULL_FLAG_N_OUT(af_n),
    .MAILBOX_AB_FLAG_N_OUT(mab_n), .PORT_A_PARITY_ERROR_N_OUT(pea_n),
    .PORT_B_SELECT_N_IN(b_sel_n), .PORT_B_ENABLE_IN(b_en),
    .PORT_B_WRITE_NOT_READ_IN(b_wnr), .PORT_B_MAILBOX_SELECT_IN(b_mb),
    .PORT_B_PARITY_GEN_IN(b_pg), .PORT_B_DATA_IN(b_d),
    .PORT_B_DATA_OUT(b_q), .PORT_B_DATA_OE_OUT(b_oe),
    .PORT_B_READ_VALID_OUT(b_vld), .PORT_B_READ_READY_IN(b_rdy),
    .EMPTY_FLAG_N_OUT(ef_n), .ALMOST_EMPTY_FLAG_N_OUT(ae_n),
    .MAILBOX_BA_FLAG_N_OUT(mba_n), .PORT_B_PARITY_ERROR_N_OUT(peb_n));

  dcfm_reader reader_u (.clk_in(port_b_clock), .go_in(go), .stall_in(stall),
    .mrd_in(mrd), .mwr_in(mwr), .md_in(md), .sel_n_out(b_sel_n),
    .en_out(b_en), .wnr_out(b_wnr), .mb_out(b_mb), .rdy_out(b_rdy),
    .d_out(b_d));

  // ****************************************************************
  // checking helpers
  // ****************************************************************
  task automatic chk(string what, logic [35:0] exp, logic [35:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(string what, logic exp, logic got);
    chk(what, 36'(exp), 36'(got));
  endtask

  task automatic complete_run;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // generated parity: byte top bit makes the chosen sense
  function automatic logic [35:0] fill(logic [35:0] w, logic o);
    for (int i = 0; i < 4; i++) w[i*9+8] = ^w[i*9 +: 8] ^ o;
    return w;
  endfunction

  function automatic logic bad(logic [35:0] w, logic o);
    bad = 0;
    for (int i = 0; i < 4; i++) bad |= (^w[i*9 +: 9]) != o;
  endfunction

  // each word taken at port b must be the oldest one written
  always @(posedge port_b_clock) begin
    if (b_vld && b_rdy && !b_mb) begin
      chk("fifo word", q.size() ? q[0] : 36'h0, b_q);
      if (q.size()) void'(q.pop_front());
    end
  end

  // ****************************************************************
  // port a driver and common sequences
  // ****************************************************************
  // one qualified edge, then the bus is let go
  task automatic a_op(logic w, logic m, logic [35:0] d);
    @(negedge clk);
    {a_sel_n, a_en, a_wnr, a_mb, a_d} = {2'b01, w, m, d};
    @(negedge clk);
    {a_sel_n, a_en} = 2'b10;
    a_d = ~a_d;
  endtask

  task automatic settle;
    repeat (8) @(negedge clk);
  endtask

  // words past the depth are refused, so they are not expected
  task automatic put(int n);
    logic [35:0] w;
    repeat (n) begin
      w = 36'hA00000000 + 36'(seq++);
      if (q.size() < 64) q.push_back(w);
      a_op(1, 0, w);
    end
  endtask

  task automatic restart(logic [1:0] s);
    @(negedge clk);
    rst_n = 0;
    {fs1, fs0} = s;
    q.delete();
    repeat (4) @(negedge clk);
    chk("reset flags", 36'(7'h26),
        36'({ff_n, af_n, ef_n, ae_n, mab_n, mba_n, b_vld}));
    rst_n = 1;
    @(posedge clk) #1 chk1("full after 1 edge", 0, ff_n);
    @(posedge clk) #1 chk1("full after 2 edges", 1, ff_n);
    settle;
  endtask

  // reads stay on while empty: no extra word may appear
  task automatic drain;
    int t = 0;
    go = 1;
    while (q.size() && t < 3000) begin
      @(negedge port_b_clock);
      t++;
    end
    repeat (8) @(negedge port_b_clock);
    go = 0;
    chk("words left", 0, 36'(q.size()));
    chk1("empty after drain", 0, ef_n);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic fill_up;
    restart(0);
    put(47);
    settle;
    chk1("room above offset", 1, af_n);
    put(1);
    settle;
    chk1("free at offset", 0, af_n);
    put(17);
    settle;
    chk1("full", 0, ff_n);
    chk1("fifo not empty", 1, ef_n);
    stall = 1;
    go = 1;
    repeat (12) @(negedge port_b_clock);
    chk1("held word valid", 1, b_vld);
    chk("held word", q[0], b_q);
    stall = 0;
    drain;
  endtask

  task automatic mail;
    a_op(1, 1, 36'h123456789);
    chk1("ab mail flag", 0, mab_n);
    a_op(1, 1, 36'h0F0F0F0F0);
    b_pg = 1;
    @(posedge port_b_clock) mrd = 1;
    @(posedge port_b_clock) chk("mail b", fill(36'h123456789, odd), b_q);
    chk1("b parity forced", 1, peb_n);
    chk1("b bus driven", 1, b_oe);
    mrd = 0;
    b_pg = 0;
    settle;
    chk1("ab flag cleared", 1, mab_n);
    md = 36'h0000000FF;
    @(posedge port_b_clock) mwr = 1;
    @(posedge port_b_clock) mwr = 0;
    settle;
    chk1("ba mail flag", 0, mba_n);
    chk("mail at a raw", md, a_q);
    @(negedge clk);
    {a_sel_n, a_en, a_wnr, a_mb, a_pg, a_d} = {5'b01011, 36'h1};
    #1 chk("mail at a gen", fill(md, odd), a_q);
    chk1("a parity forced", 1, pea_n);
    chk1("a bus driven", 1, a_oe);
    @(negedge clk);
    {a_sel_n, a_en, a_pg} = 3'b100;
    settle;
    chk1("ba flag cleared", 1, mba_n);
  endtask

  task automatic parity;
    logic [35:0] w[3] = '{36'h0, 36'h1, 36'h100000101};
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      odd = i[0];
      a_d = w[i/2];
      #1 chk1("a parity flag", !bad(a_d, odd), pea_n);
      chk1("b parity flag", !bad(b_d, odd), peb_n);
    end
    odd = 0;
  endtask

  task automatic offsets;
    int off[4] = '{16, 12, 8, 4};
    for (int s = 0; s < 4; s++) begin
      restart(s[1:0]);
      put(off[s]);
      settle;
      chk1("stored at offset", 0, ae_n);
      put(1);
      settle;
      chk1("stored above offset", 1, ae_n);
      drain;
    end
  endtask

  // ****************************************************************
  // run and watchdog
  // ****************************************************************
  initial begin
    fill_up;
    mail;
    parity;
    offsets;
    complete_run;
  end

  initial begin
    #1500000;
    n_mismatch++;
    complete_run;
  end
endmodule

`default_nettype wire
